//--- hdl/supply_sequencing_timers.sv
`include "seq_defs.svh"

// How it works
// [RULE_01] Enable output rises only after the on-delay counted on shared timebase ticks.
// [RULE_02] Servo starts after rise interval on shared ticks, only when DAC mode is 00.
// [RULE_03] Rise-timeout fault if output misses undervoltage limit within programmed time.
// [RULE_04] Reaching the undervoltage limit in time unmasks undervoltage detection.
// [RULE_05] A zero rise-timeout limit disables the timeout entirely.
// [RULE_06] Run or operation off waits the off-delay, then drops the enable.
// [RULE_07] Off-delay counts shared ticks when present, else internal oscillator ticks.
// [RULE_08] Sequencing delays are clamped to 655 ms with 10 us resolution.
// [RULE_09] Register reads return the raw value last written.
// [RULE_10] Run low for at least 10 us then high triggers a restart.
// [RULE_11] Restart drops the channel, holds it off, then runs the on sequence.
// [RULE_12] Off periods longer than hold-off are normal off and on transitions; the off time counts shared ticks only.
// [RULE_13] A zero hold-off disables the restart feature.
// [RULE_14] Hold-off is clamped to 13.1 s in 200 us steps; readback stays raw.
// [RULE_15] All timing registers use one shared millisecond encoding.
// [RULE_16] Off request during on-delay or rise cancels those timers first.
module supply_sequencing_timers
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic share_clk_in,
    input wire logic run_ctrl_in,
    input wire logic operation_on_in,
    input wire logic [1:0] dac_mode_in,
    input wire logic uv_ok_in,
    output logic converter_enable_output,
    output logic servo_enable_out,
    output logic uv_unmask_out,
    output logic rise_timeout_fault_out,
    output logic share_present_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rst_pipe_r <= 2'h0;
        else
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end

    assign rst_n = rst_pipe_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: index 0 shared clock, index 1 run control
    logic [1:0] pin_raw;
    logic [1:0] pin_stable;

    assign pin_raw = {run_ctrl_in, share_clk_in};

    generate
        for (genvar p = 0; p < 2; p++)
        begin : g_sync
            logic [2:0] sync_r;
            logic stable_r;
            logic stable_nxt;

            // Stable only updates when stages two and three agree, filtering glitches
            always_comb
            begin
                stable_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : stable_r;
            end

            always_ff @(posedge clock_in or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync_r <= 3'h0;
                    stable_r <= 1'b0;
                end
                else
                begin
                    sync_r <= {sync_r[1:0], pin_raw[p]};
                    stable_r <= stable_nxt;
                end
            end

            assign pin_stable[p] = stable_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Timebases
    logic [11:0] osc_cnt_r;
    logic [11:0] osc_cnt_nxt;
    logic share_prev_r;
    logic [1:0] share_idle_r;
    logic [1:0] share_idle_nxt;
    logic osc_tick;
    logic share_tick;
    logic off_tick;

    assign osc_tick = (osc_cnt_r == 12'(`TICK_CYCLES - 1));
    assign share_tick = share_prev_r && !pin_stable[0];
    assign share_present_out = (share_idle_r != `SHARE_LOSS_TICKS);
    assign off_tick = share_present_out ? share_tick : osc_tick; // RULE_07

    always_comb
    begin
        osc_cnt_nxt = osc_tick ? 12'h000 : osc_cnt_r + 12'h001;
        share_idle_nxt = share_idle_r;
        if (share_tick)
            share_idle_nxt = 2'h0;
        else if (osc_tick && share_present_out)
            share_idle_nxt = share_idle_r + 2'h1;
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_cnt_r <= 12'h000;
            share_prev_r <= 1'b0;
            share_idle_r <= `SHARE_LOSS_TICKS;
        end
        else
        begin
            osc_cnt_r <= osc_cnt_nxt;
            share_prev_r <= pin_stable[0];
            share_idle_r <= share_idle_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register store
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            `ADDR_TURN_ON_DELAY: reg_index = `IDX_TURN_ON_DELAY;
            `ADDR_RISE_INTERVAL: reg_index = `IDX_RISE_INTERVAL;
            `ADDR_RISE_TIMEOUT_LIMIT: reg_index = `IDX_RISE_TIMEOUT_LIMIT;
            `ADDR_TURN_OFF_DELAY: reg_index = `IDX_TURN_OFF_DELAY;
            `ADDR_RESTART_HOLD_OFF: reg_index = `IDX_RESTART_HOLD_OFF;
            default: reg_index = `IDX_NONE;
        endcase
    endfunction

    logic [`REG_COUNT-1:0][15:0] raw_r;
    logic [`REG_COUNT-1:0][15:0] raw_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;

    assign wr_idx = reg_index(reg_addr_in);
    assign rd_idx = reg_index(reg_addr_in);

    // Raw words are kept; clamping lives only in the tick converters
    always_comb
    begin
        raw_nxt = raw_r;
        rdata_nxt = rdata_r;
        if (reg_wr_in && wr_idx != `IDX_NONE)
            raw_nxt[wr_idx] = reg_wdata_in; // RULE_09
        if (reg_rd_in)
            rdata_nxt = (rd_idx == `IDX_NONE) ? 16'h0000 : raw_r[rd_idx]; // RULE_09
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_r[`IDX_TURN_ON_DELAY] <= `RST_TURN_ON_DELAY;
            raw_r[`IDX_RISE_INTERVAL] <= `RST_RISE_INTERVAL;
            raw_r[`IDX_RISE_TIMEOUT_LIMIT] <= `RST_RISE_TIMEOUT_LIMIT;
            raw_r[`IDX_TURN_OFF_DELAY] <= `RST_TURN_OFF_DELAY;
            raw_r[`IDX_RESTART_HOLD_OFF] <= `RST_RESTART_HOLD_OFF;
            rdata_r <= 16'h0000;
        end
        else
        begin
            raw_r <= raw_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Word to tick conversion, one converter per register
    seq_pkg::ticks_t ticks [`REG_COUNT];

    generate
        for (genvar r = 0; r < `REG_COUNT; r++)
        begin : g_conv
            l11_ticks u_conv
            (
                .clock_in(clock_in),
                .rst_b_in(rst_n),
                .word_in(raw_r[r]),
                .hold_in(r == `REG_COUNT - 1),
                .ticks_out(ticks[r])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Run-control off measurement
    logic req;
    logic req_prev_r;
    logic run_prev_r;
    logic run_rise;
    logic [11:0] low_cyc_r;
    logic [11:0] low_cyc_nxt;
    logic [20:0] low_ticks_r;
    logic [20:0] low_ticks_nxt;
    logic restart_go;
    logic [20:0] hold_ticks;

    assign req = pin_stable[1] && operation_on_in;
    assign run_rise = pin_stable[1] && !run_prev_r;
    assign hold_ticks = ticks[`IDX_RESTART_HOLD_OFF];
    // Drops of 10 us up to the hold-off restart; shorter or longer ones and a zero hold-off fall through to normal on
    assign restart_go = run_rise && operation_on_in
        && low_cyc_r >= 12'(`MIN_OFF_CYCLES) // RULE_10
        && hold_ticks != 21'h000000 // RULE_13
        && low_ticks_r <= hold_ticks; // RULE_12

    always_comb
    begin
        low_cyc_nxt = low_cyc_r;
        low_ticks_nxt = low_ticks_r;
        if (pin_stable[1])
        begin
            low_cyc_nxt = 12'h000;
            low_ticks_nxt = 21'h000000;
        end
        else
        begin
            if (low_cyc_r < 12'(`MIN_OFF_CYCLES))
                low_cyc_nxt = low_cyc_r + 12'h001;
            if (share_tick && low_ticks_r != 21'h1FFFFF)
                low_ticks_nxt = low_ticks_r + 21'h000001;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_prev_r <= 1'b0;
            run_prev_r <= 1'b0;
            low_cyc_r <= 12'h000;
            low_ticks_r <= 21'h000000;
        end
        else
        begin
            req_prev_r <= req;
            run_prev_r <= pin_stable[1];
            low_cyc_r <= low_cyc_nxt;
            low_ticks_r <= low_ticks_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    seq_pkg::seq_state_e state_r;
    seq_pkg::seq_state_e state_nxt;
    logic en_r;
    logic en_nxt;
    logic fault_r;
    logic fault_nxt;
    logic unmask_r;
    logic unmask_nxt;
    logic servo_r;
    logic servo_nxt;
    logic load_a;
    logic tick_a;
    logic [20:0] val_a;
    logic done_a;
    logic load_t;
    logic cancel_t;
    logic done_t;
    logic busy_t;

    always_comb
    begin
        state_nxt = state_r;
        en_nxt = en_r;
        load_a = 1'b0;
        val_a = ticks[`IDX_TURN_ON_DELAY];
        tick_a = share_tick; // RULE_01 RULE_02 RULE_11
        unique case (state_r)
            seq_pkg::ST_IDLE:
            begin
                if (restart_go)
                begin
                    state_nxt = seq_pkg::ST_HOLD;
                    load_a = 1'b1;
                    val_a = hold_ticks;
                end
                else if (req && !req_prev_r)
                begin
                    state_nxt = seq_pkg::ST_ON_DLY;
                    load_a = 1'b1;
                end
            end
            seq_pkg::ST_ON_DLY, seq_pkg::ST_RISE, seq_pkg::ST_ON:
            begin
                if (!req)
                begin
                    // Reload replaces any pending count
                    state_nxt = seq_pkg::ST_OFF_DLY; // RULE_16
                    load_a = 1'b1;
                    val_a = ticks[`IDX_TURN_OFF_DELAY];
                end
                else if (state_r == seq_pkg::ST_ON_DLY && done_a)
                begin
                    state_nxt = seq_pkg::ST_RISE;
                    en_nxt = 1'b1; // RULE_01
                    load_a = 1'b1;
                    val_a = ticks[`IDX_RISE_INTERVAL];
                end
                else if (state_r == seq_pkg::ST_RISE && done_a)
                begin
                    state_nxt = seq_pkg::ST_ON; // RULE_02
                end
            end
            seq_pkg::ST_OFF_DLY:
            begin
                tick_a = off_tick; // RULE_07
                if (restart_go)
                begin
                    state_nxt = seq_pkg::ST_HOLD;
                    en_nxt = 1'b0; // RULE_11
                    load_a = 1'b1;
                    val_a = hold_ticks;
                end
                else if (req && !req_prev_r)
                begin
                    state_nxt = seq_pkg::ST_ON_DLY;
                    en_nxt = 1'b0;
                    load_a = 1'b1;
                end
                else if (done_a)
                begin
                    state_nxt = seq_pkg::ST_IDLE;
                    en_nxt = 1'b0; // RULE_06
                end
            end
            seq_pkg::ST_HOLD:
            begin
                if (done_a)
                begin
                    state_nxt = req ? seq_pkg::ST_ON_DLY : seq_pkg::ST_IDLE; // RULE_11
                    load_a = req;
                end
            end
        endcase
    end

    // Fault sets win over the clear at a new on sequence
    always_comb
    begin
        load_t = en_nxt && !en_r && ticks[`IDX_RISE_TIMEOUT_LIMIT] != 21'h000000; // RULE_05
        cancel_t = uv_ok_in || !en_r;
        fault_nxt = fault_r;
        if (state_nxt == seq_pkg::ST_ON_DLY && state_r != seq_pkg::ST_ON_DLY)
            fault_nxt = 1'b0;
        if (done_t)
            fault_nxt = 1'b1; // RULE_03
        unmask_nxt = en_r && (unmask_r || (uv_ok_in && !fault_r && !done_t)); // RULE_04
        servo_nxt = state_nxt == seq_pkg::ST_ON && dac_mode_in == `DAC_MODE_SERVO; // RULE_02
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= seq_pkg::ST_IDLE;
            en_r <= 1'b0;
            fault_r <= 1'b0;
            unmask_r <= 1'b0;
            servo_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            en_r <= en_nxt;
            fault_r <= fault_nxt;
            unmask_r <= unmask_nxt;
            servo_r <= servo_nxt;
        end
    end

    seq_timer u_phase
    (
        .clock_in(clock_in),
        .rst_b_in(rst_n),
        .load_in(load_a),
        .cancel_in(1'b0),
        .value_in(val_a),
        .tick_in(tick_a),
        .busy_out(),
        .done_out(done_a)
    );

    seq_timer u_timeout
    (
        .clock_in(clock_in),
        .rst_b_in(rst_n),
        .load_in(load_t),
        .cancel_in(cancel_t),
        .value_in(ticks[`IDX_RISE_TIMEOUT_LIMIT]),
        .tick_in(share_tick), // RULE_03
        .busy_out(busy_t),
        .done_out(done_t)
    );

    assign converter_enable_output = en_r;
    assign servo_enable_out = servo_r;
    assign uv_unmask_out = unmask_r;
    assign rise_timeout_fault_out = fault_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_on_wait_done;
        state_r == seq_pkg::ST_ON_DLY && done_a && req;
    endsequence

    enable_after_delay_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_01
        $rose(en_r) |-> $past(state_r) == seq_pkg::ST_ON_DLY && $past(done_a))
        else $error("Enable rose without on-delay expiry");

    on_seq_step_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_01
        s_on_wait_done |=> en_r && state_r == seq_pkg::ST_RISE)
        else $error("On-delay expiry did not enable");

    servo_mode_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_02
        servo_enable_out |-> $past(dac_mode_in) == `DAC_MODE_SERVO && state_r == seq_pkg::ST_ON)
        else $error("Servo without mode 00 or outside on");

    timeout_fault_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_03
        done_t |=> rise_timeout_fault_out)
        else $error("Rise timeout did not raise fault");

    uv_unmask_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_04
        en_r && uv_ok_in && !fault_r && !done_t |=> uv_unmask_out)
        else $error("Undervoltage not unmasked");

    zero_timeout_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_05
        ticks[`IDX_RISE_TIMEOUT_LIMIT] == 21'h000000 && !busy_t |=> !done_t)
        else $error("Zero timeout still expired");

    off_delay_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_06
        $fell(en_r) |-> $past(done_a) || $past(restart_go) || $past(req && !req_prev_r))
        else $error("Enable dropped without off-delay");

    readback_raw_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_09
        reg_wr_in && reg_index(reg_addr_in) == `IDX_TURN_OFF_DELAY
        |=> raw_r[`IDX_TURN_OFF_DELAY] == $past(reg_wdata_in))
        else $error("Written word not kept raw");

    hold_off_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_11
        state_r == seq_pkg::ST_HOLD |-> !converter_enable_output)
        else $error("Channel on during hold-off");

    restart_zero_a : assert property (@(posedge clock_in) disable iff (!rst_n) // RULE_13
        hold_ticks == 21'h000000 |-> !restart_go)
        else $error("Restart with hold-off disabled");

endmodule

//--- hdl/seq_defs.svh
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// Register addresses
`define ADDR_TURN_ON_DELAY 8'h60
`define ADDR_RISE_INTERVAL 8'h61
`define ADDR_RISE_TIMEOUT_LIMIT 8'h62
`define ADDR_TURN_OFF_DELAY 8'h64
`define ADDR_RESTART_HOLD_OFF 8'hDC

// Register indices inside the raw store
`define IDX_TURN_ON_DELAY 3'h0
`define IDX_RISE_INTERVAL 3'h1
`define IDX_RISE_TIMEOUT_LIMIT 3'h2
`define IDX_TURN_OFF_DELAY 3'h3
`define IDX_RESTART_HOLD_OFF 3'h4
`define IDX_NONE 3'h7
`define REG_COUNT 5

// Reset values
`define RST_TURN_ON_DELAY 16'hBA00
`define RST_RISE_INTERVAL 16'hD280
`define RST_RISE_TIMEOUT_LIMIT 16'hD3C0
`define RST_TURN_OFF_DELAY 16'hBA00
`define RST_RESTART_HOLD_OFF 16'hFB20

// Field positions of the shared word encoding
`define EXP_MSB 15
`define EXP_LSB 11
`define MANT_SIGN 10
`define MANT_MSB 9

// Timing
`define CLK_MHZ 200
`define TICK_US 10
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define MIN_OFF_US 10
`define MIN_OFF_CYCLES (`MIN_OFF_US * `CLK_MHZ)
`define SHARE_LOSS_TICKS 2'h3
`define TICKS_PER_MS 17'h00064
`define HOLD_STEPS_PER_MS 17'h00005
`define HOLD_STEP_TICKS 21'h000014
`define STEP_MAX 17'h0FFDC
`define TICK_W 21
`define DAC_MODE_SERVO 2'h0

`endif

//--- hdl/seq_pkg.sv
package seq_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ON_DLY,
        ST_RISE,
        ST_ON,
        ST_OFF_DLY,
        ST_HOLD
    } seq_state_e;

    typedef logic [20:0] ticks_t;

endpackage

//--- hdl/l11_ticks.sv
`include "seq_defs.svh"

module l11_ticks
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [15:0] word_in,
    input wire logic hold_in,
    output logic [20:0] ticks_out
);

    logic [4:0] expo;
    logic [4:0] nshift;
    logic [16:0] mant;
    logic [16:0] prod;
    logic [47:0] wide;
    logic [16:0] steps;
    logic [20:0] ticks_nxt;
    logic [20:0] ticks_r;

    ////////////////////////////////////////////////////////////////////////////
    // Negative durations make no sense, so they count as zero
    always_comb
    begin
        expo = word_in[`EXP_MSB:`EXP_LSB];
        nshift = 5'(-expo);
        mant = word_in[`MANT_SIGN] ? 17'h00000 : {7'h00, word_in[`MANT_MSB:0]};
        prod = mant * (hold_in ? `HOLD_STEPS_PER_MS : `TICKS_PER_MS);
        if (!expo[4])
        begin
            wide = {31'h0, prod} << expo[3:0];
        end
        else
        begin
            // Round to nearest step
            wide = ({31'h0, prod} + (48'h1 << (nshift - 5'h01))) >> nshift;
        end
        steps = (wide > {31'h0, `STEP_MAX}) ? `STEP_MAX : wide[16:0]; // RULE_08 RULE_14
        ticks_nxt = hold_in ? 21'(steps) * `HOLD_STEP_TICKS : 21'(steps); // RULE_15
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            ticks_r <= 21'h000000;
        else
            ticks_r <= ticks_nxt;
    end

    assign ticks_out = ticks_r;

    ticks_clamped_a : assert property (@(posedge clock_in) disable iff (!rst_b_in) // RULE_08
        !hold_in |-> ##1 ticks_out <= 21'(`STEP_MAX))
        else $error("Delay ticks exceed clamp");

endmodule

//--- hdl/seq_timer.sv
module seq_timer
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic load_in,
    input wire logic cancel_in,
    input wire logic [20:0] value_in,
    input wire logic tick_in,
    output logic busy_out,
    output logic done_out
);

    logic [20:0] cnt_r;
    logic [20:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic done_r;
    logic done_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (load_in)
        begin
            cnt_nxt = value_in;
            run_nxt = (value_in != 21'h000000);
            done_nxt = (value_in == 21'h000000);
        end
        else if (cancel_in)
        begin
            run_nxt = 1'b0;
        end
        else if (run_r && tick_in)
        begin
            if (cnt_r == 21'h000001)
            begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            cnt_nxt = cnt_r - 21'h000001;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_r <= 21'h000000;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = run_r;
    assign done_out = done_r;

    done_has_cause_a : assert property (@(posedge clock_in) disable iff (!rst_b_in)
        done_out |-> $past(load_in) || ($past(run_r) && $past(tick_in)))
        else $error("Timer done without load or tick");

endmodule

//--- bench/dcdc_model.sv
module dcdc_model
(
    input wire logic clock_in,
    input wire logic enable_in,
    input wire logic dead_in,
    output logic uv_ok_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Output climbs for 40 cycles; a dead supply never gets there
    always @(posedge clock_in)
    begin
        cnt <= enable_in ? cnt + 1 : 0;
        uv_ok_out <= enable_in && !dead_in && cnt >= 40;
    end
endmodule

//--- bench/supply_sequencing_timers_tb.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module supply_sequencing_timers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, share = 1, op = 0, dead = 0;
    logic run = 1, share_run = 1;
    logic uv_ok, en, servo, unmask, fault, present;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, v;
    logic [2:0] obs;
    int fail_count = 0, num_checks = 0, tk = 0, cyc = 0, t;
    logic [7:0] addrs [5] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'hDC};
    logic [15:0] rstv [5] = '{16'hBA00, 16'hD280, 16'hD3C0, 16'hBA00, 16'hFB20};
    // Quarter-ms steps keep the run short: 25, 50, 200, 25 ticks
    logic [15:0] cfg [5] = '{16'hF001, 16'hF002, 16'hF008, 16'hF001, 16'h7FFF};
    assign obs = {fault, servo, en};
    supply_sequencing_timers i_supply_sequencing_timers
    (
        .clock_in(clk),
        .rst_b_in(rst_b),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(wr),
        .reg_rd_in(rd),
        .reg_rdata_out(rdata),
        .share_clk_in(share),
        .run_ctrl_in(run),
        .operation_on_in(op),
        .dac_mode_in(2'h0),
        .uv_ok_in(uv_ok),
        .converter_enable_output(en),
        .servo_enable_out(servo),
        .uv_unmask_out(unmask),
        .rise_timeout_fault_out(fault),
        .share_present_out(present)
    );
    dcdc_model i_dcdc_model
    (
        .clock_in(clk),
        .enable_in(en),
        .dead_in(dead),
        .uv_ok_out(uv_ok)
    );
    ////////////////////////////////////////////////////////////////////////
    initial forever #2.5 clk = ~clk;
    // Fast shared timebase, one tick every 8 cycles
    always @(posedge clk)
    begin
        cyc++;
        // A released line floats to its pull-up level
        if (cyc % 4 == 3)
            share <= share_run ? ~share : 1'b1;
        if (cyc > 60000)
        begin
            fail_count++;
            stop_test();
        end
    end
    always @(negedge share) tk++;
    ////////////////////////////////////////////////////////////////////////
    task stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    // Ticks until the chosen output reaches the level; bounded wait
    task wait_out(input int sel, input logic lvl, output int n);
        int c;
        c = 0;
        n = tk;
        while (obs[sel] !== lvl && c < 20000)
        begin
            @(posedge clk);
            c++;
        end
        n = tk - n;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(present, 1'b0)
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(addrs[i], v);
            `CHK(v, rstv[i])
            wr_reg(addrs[i], cfg[i]);
            rd_reg(addrs[i], v);
            `CHK(v, cfg[i])
        end
        rd_reg(8'h63, v);
        `CHK(v, 16'h0000)
        $display("test registers done");
        op <= 1'b1;
        wait_out(0, 1'b1, t);
        `CHK(t inside {[25:26]}, 1'b1)
        wait_out(1, 1'b1, t);
        `CHK(t inside {[50:51]}, 1'b1)
        `CHK(unmask, 1'b1)
        `CHK(fault, 1'b0)
        `CHK(present, 1'b1)
        op <= 1'b0;
        wait_out(0, 1'b0, t);
        `CHK(t inside {[25:26]}, 1'b1)
        $display("test on off done");
        dead <= 1'b1;
        op <= 1'b1;
        wait_out(0, 1'b1, t);
        wait_out(2, 1'b1, t);
        `CHK(t inside {[200:201]}, 1'b1)
        `CHK(unmask, 1'b0)
        op <= 1'b0;
        wait_out(0, 1'b0, t);
        $display("test timeout done");
        wr_reg(8'h62, 16'h0000);
        op <= 1'b1;
        wait_out(0, 1'b1, t);
        repeat (2400) @(posedge clk);
        `CHK(fault, 1'b0)
        op <= 1'b0;
        wait_out(0, 1'b0, t);
        $display("test no limit done");
        // Off during the on-delay must leave the converter off
        op <= 1'b1;
        repeat (80) @(posedge clk);
        op <= 1'b0;
        // An uncancelled on-delay would enable well before this point
        repeat (200) @(posedge clk);
        `CHK(en, 1'b0)
        repeat (400) @(posedge clk);
        `CHK(en, 1'b0)
        $display("test cancel done");
        // Hold-off of 3 ms is 300 ticks; a 2100-cycle drop is about 262 ticks
        wr_reg(8'hDC, 16'h0003);
        op <= 1'b1;
        wait_out(0, 1'b1, t);
        run <= 1'b0;
        repeat (2100) @(posedge clk);
        `CHK(en, 1'b0)
        run <= 1'b1;
        wait_out(0, 1'b1, t);
        `CHK(t inside {[325:326]}, 1'b1)
        run <= 1'b0;
        repeat (2600) @(posedge clk);
        run <= 1'b1;
        wait_out(0, 1'b1, t);
        `CHK(t inside {[25:26]}, 1'b1)
        $display("test restart done");
        // Without the shared line the off-delay runs on 2000-cycle ticks: 6 of them
        wr_reg(8'h64, 16'hE001);
        share_run <= 1'b0;
        repeat (6500) @(posedge clk);
        `CHK(present, 1'b0)
        op <= 1'b0;
        repeat (9900) @(posedge clk);
        `CHK(en, 1'b1)
        repeat (2300) @(posedge clk);
        `CHK(en, 1'b0)
        $display("test oscillator done");
        stop_test();
    end
endmodule
